//--- common/mbc_defines.vh
// Constants for the MAC transmit/receive control and backoff block
// What this block does
// [RL1] After collision wait random r slots, 0<=r<2^K, K=min(retries,10).
// [RL2] Limit select 00 caps countdown at 10 bits, 01 at 8, 10 at 4.
// [RL3] Countdown loads from LFSR low bits; limit select 11 uses one bit.
// [RL4] Countdown decrements once per slot time of 512 bit times.
// [RL5] With deferral check set, abort after deferring over 24288 bit times.
// [RL6] Deferral timer starts when frame ready but carrier sense holds off.
// [RL7] Deferral time never accumulates; each new deferral restarts from zero.
// [RL8] With deferral check clear, no timeout; deferral may last forever.
// [RL9] Transmit enable set sends frames; clear sends none.
// [RL10] Receive enable set accepts PHY frames; clear accepts none.
// [RL11] Software sets receive DMA start before setting receive enable.
// [RL12] Software clears receive enable before clearing receive DMA start.
// [RL13] DMA stop while receiver enabled keeps state running, no stopped flag.
// [RL14] Reset clears both enables and sets backoff limit select to 00.
`ifndef MBC_DEFINES_VH
`define MBC_DEFINES_VH
`define MBC_SLOT_BITS 512
`define MBC_DEFER_BITS 24288
`define MBC_K_MAX 4'ha
`define MBC_K_CAP_8 4'h8
`define MBC_K_CAP_4 4'h4
`define MBC_K_CAP_1 4'h1
`define MBC_CNT_W 10
`define MBC_LFSR_TAP_A 19
`define MBC_LFSR_TAP_B 16
`define MBC_LIM_10 2'h0
`define MBC_LIM_8 2'h1
`define MBC_LIM_4 2'h2
`define MBC_LIM_1 2'h3
`define MBC_LFSR_SEED 20'h00001
`define MBC_RS_STOPPED 1'h0
`define MBC_RS_RUNNING 1'h1
`endif

//--- rtl/mbc_mac_ctrl.v
// MAC transmit/receive control, backoff and deferral logic
`timescale 1ns/1ps
`include "mbc_defines.vh"
module mbc_mac_ctrl #(
   parameter BIT_CYCLES = 8'd5,
   parameter RETRY_W = 5
) (
   // Clock and reset
   input wire sysClk,
   input wire rst_n,
   // Control bits from software
   input wire backoffLimitWe,
   input wire [1:0] backoffLimitIn,
   input wire deferralCheckEnIn,
   input wire transmitterEnableIn,
   input wire receiverEnableIn,
   input wire rxDmaStartStop,
   // Transmit side
   input wire txFrameReady,
   input wire carrierSense,
   input wire collision,
   input wire [RETRY_W-1:0] retryCount,
   output wire txStart,
   output reg txBackoffBusy_ff,
   output reg txDeferAbort_ff,
   // Receive side
   input wire phyRxValid,
   input wire [7:0] phyRxData,
   output reg rxValid_ff,
   output reg [7:0] rxData_ff,
   output reg rxProcessState_ff,
   output reg rxProcessStoppedFlag_ff,
   // Control readback
   output reg [1:0] backoffLimitSel_ff,
   output reg transmitterEnable_ff,
   output reg receiverEnable_ff,
   output reg deferralCheckEn_ff
);
   ////////////////////////////////////////////////////////////////////////
   // Control bits
   // Backoff limit field, written only on its strobe
   always @(posedge sysClk or negedge rst_n) begin
      if (!rst_n) begin
         backoffLimitSel_ff <= `MBC_LIM_10; // RL14
      end else if (backoffLimitWe) begin
         backoffLimitSel_ff <= backoffLimitIn; // RL2
      end
   end
   // Transmit enable
   always @(posedge sysClk or negedge rst_n) begin
      if (!rst_n) begin
         transmitterEnable_ff <= 1'b0; // RL14
      end else begin
         transmitterEnable_ff <= transmitterEnableIn; // RL9
      end
   end
   // Receive enable
   always @(posedge sysClk or negedge rst_n) begin
      if (!rst_n) begin
         receiverEnable_ff <= 1'b0; // RL14
      end else begin
         receiverEnable_ff <= receiverEnableIn; // RL10
      end
   end
   // Deferral check enable, off after reset
   always @(posedge sysClk or negedge rst_n) begin
      if (!rst_n) begin
         deferralCheckEn_ff <= 1'b0; // RL8
      end else begin
         deferralCheckEn_ff <= deferralCheckEnIn; // RL8
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Bit time and slot time ticks
   reg [7:0] bitCnt_ff;
   reg [9:0] slotCnt_ff;
   wire bitTick;
   wire slotTick;
   // One bit time is BIT_CYCLES clocks
   assign bitTick = (bitCnt_ff == BIT_CYCLES - 8'd1);
   // One slot time is a fixed number of bit times
   assign slotTick = bitTick && (slotCnt_ff == `MBC_SLOT_BITS - 1); // RL4
   // Bit time counter, free running
   always @(posedge sysClk or negedge rst_n) begin
      if (!rst_n) begin
         bitCnt_ff <= 8'h00;
      end else begin
         bitCnt_ff <= bitTick ? 8'h00 : bitCnt_ff + 8'h01;
      end
   end
   // Slot time counter, steps on bit ticks
   always @(posedge sysClk or negedge rst_n) begin
      if (!rst_n) begin
         slotCnt_ff <= 10'h000;
      end else if (bitTick) begin
         slotCnt_ff <= slotTick ? 10'h000 : slotCnt_ff + 10'h001;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // LFSR and backoff countdown
   reg [19:0] lfsr_ff;
   reg [9:0] backoffCnt_ff;
   reg [3:0] kEff;
   wire [9:0] mask;
   wire [3:0] kRetry;
   genvar g;
   // Exponent is the retry count, never above ten
   assign kRetry = (retryCount > `MBC_K_MAX) ? `MBC_K_MAX :
      retryCount[3:0]; // RL1
   // Limit select caps the exponent
   always @* begin
      kEff = kRetry;
      case (backoffLimitSel_ff) // RL2
         `MBC_LIM_10: begin
            kEff = kRetry;
         end
         `MBC_LIM_8: begin
            kEff = (kRetry > `MBC_K_CAP_8) ? `MBC_K_CAP_8 : kRetry;
         end
         `MBC_LIM_4: begin
            kEff = (kRetry > `MBC_K_CAP_4) ? `MBC_K_CAP_4 : kRetry;
         end
         default: begin
            kEff = (kRetry > `MBC_K_CAP_1) ? `MBC_K_CAP_1 : kRetry; // RL3
         end
      endcase
   end
   // One mask bit per countdown bit below the exponent
   generate
      for (g = 0; g < `MBC_CNT_W; g = g + 1) begin : g_mask
         assign mask[g] = (g < kEff);
      end
   endgenerate
   // Free-running pseudo-random source
   always @(posedge sysClk or negedge rst_n) begin
      if (!rst_n) begin
         lfsr_ff <= `MBC_LFSR_SEED;
      end else begin
         lfsr_ff <= {lfsr_ff[18:0],
            lfsr_ff[`MBC_LFSR_TAP_A] ^ lfsr_ff[`MBC_LFSR_TAP_B]};
      end
   end
   // Countdown loads on collision, steps once per slot
   // A new collision reloads the countdown at once
   always @(posedge sysClk or negedge rst_n) begin
      if (!rst_n) begin
         backoffCnt_ff <= 10'h000;
         txBackoffBusy_ff <= 1'b0;
      end else begin
         if (collision) begin
            backoffCnt_ff <= lfsr_ff[9:0] & mask; // RL1 RL3
            txBackoffBusy_ff <= 1'b1;
         end else if (txBackoffBusy_ff && slotTick) begin
            if (backoffCnt_ff == 10'h000) begin
               txBackoffBusy_ff <= 1'b0;
            end else begin
               backoffCnt_ff <= backoffCnt_ff - 10'h001; // RL4
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Deferral timer
   reg [14:0] deferCnt_ff;
   wire deferring;
   // Held off by carrier with a frame waiting and no backoff running
   assign deferring = transmitterEnable_ff && txFrameReady && carrierSense &&
      !txBackoffBusy_ff; // RL6
   // Counts bit times while deferring, clears otherwise
   always @(posedge sysClk or negedge rst_n) begin
      if (!rst_n) begin
         deferCnt_ff <= 15'h0000;
         txDeferAbort_ff <= 1'b0;
      end else begin
         txDeferAbort_ff <= 1'b0;
         if (!deferring) begin
            deferCnt_ff <= 15'h0000; // RL7
         end else if (bitTick) begin
            if (deferCnt_ff == `MBC_DEFER_BITS) begin
               if (deferralCheckEn_ff) begin // RL8
                  txDeferAbort_ff <= 1'b1; // RL5
                  deferCnt_ff <= 15'h0000;
               end
            end else begin
               deferCnt_ff <= deferCnt_ff + 15'h0001; // RL6
            end
         end
      end
   end
   // Transmission starts only when enabled, idle medium and no backoff
   assign txStart = transmitterEnable_ff && txFrameReady && !carrierSense &&
      !txBackoffBusy_ff && !collision; // RL9
   ////////////////////////////////////////////////////////////////////////
   // Receive path and receive process state
   // Receive byte path
   always @(posedge sysClk or negedge rst_n) begin
      if (!rst_n) begin
         rxValid_ff <= 1'b0;
         rxData_ff <= 8'h00;
      end else begin
         // Byte passes only while the receiver is enabled
         rxValid_ff <= receiverEnable_ff && phyRxValid; // RL10
         if (receiverEnable_ff && phyRxValid) begin
            rxData_ff <= phyRxData; // RL10
         end
      end
   end
   // Receive process state and stopped flag
   // Stop takes effect only once the receiver is disabled
   always @(posedge sysClk or negedge rst_n) begin
      if (!rst_n) begin
         rxProcessState_ff <= `MBC_RS_STOPPED;
         rxProcessStoppedFlag_ff <= 1'b0;
      end else if (rxDmaStartStop) begin
         // DMA start clears the stopped flag
         rxProcessState_ff <= `MBC_RS_RUNNING; // RL11
         rxProcessStoppedFlag_ff <= 1'b0;
      end else if (receiverEnable_ff) begin
         // Stop while receiving: stay running, no flag
         rxProcessState_ff <= rxProcessState_ff; // RL13
      end else if (rxProcessState_ff == `MBC_RS_RUNNING) begin
         // Orderly shutdown reaches the stopped state
         rxProcessState_ff <= `MBC_RS_STOPPED; // RL12
         rxProcessStoppedFlag_ff <= 1'b1;
      end
   end
endmodule // mbc_mac_ctrl

//--- bench/mbc_mac_ctrl_monitor.sv
// Port checker for the MAC control block
`timescale 1ns/1ps
module mbc_mac_ctrl_monitor (
   input wire sysClk, rst_n, collision, phyRxValid, transmitterEnableIn,
   input wire [7:0] phyRxData, rxData_ff,
   input wire txStart, txBackoffBusy_ff, txDeferAbort_ff, rxValid_ff,
   input wire rxProcessStoppedFlag_ff, transmitterEnable_ff,
   input wire receiverEnable_ff, deferralCheckEn_ff
);
   default clocking @(posedge sysClk); endclocking
   default disable iff (!rst_n);
   sequence s_bo; collision ##1 txBackoffBusy_ff; endsequence
   property p_bo; collision |-> s_bo; endproperty
   property p_slot; txBackoffBusy_ff |-> !txStart; endproperty
   property p_tx; !transmitterEnable_ff |-> !txStart; endproperty
   property p_ten; $rose(transmitterEnableIn) |=> transmitterEnable_ff;
   endproperty
   property p_rx; rxValid_ff |-> $past(phyRxValid) &&
      rxData_ff == $past(phyRxData); endproperty
   property p_off; !deferralCheckEn_ff |-> !txDeferAbort_ff; endproperty
   property p_ab; txDeferAbort_ff |=> !txDeferAbort_ff; endproperty
   property p_dma; $rose(rxProcessStoppedFlag_ff) |->
      !$past(receiverEnable_ff); endproperty
   a_bo: assert property (p_bo) else $error("no backoff");
   a_slot: assert property (p_slot) else $error("start in backoff");
   a_tx: assert property (p_tx) else $error("start while off");
   a_ten: assert property (p_ten) else $error("enable lost");
   a_rx: assert property (p_rx) else $error("bad rx byte");
   a_off: assert property (p_off) else $error("abort unchecked");
   a_ab: assert property (p_ab) else $error("long abort");
   a_dma: assert property (p_dma) else $error("early stop");
endmodule // mbc_mac_ctrl_monitor
bind mbc_mac_ctrl mbc_mac_ctrl_monitor i_mon (.*);

//--- bench/mbc_phy_model.sv
// Media side model: carrier, collision and receive bytes
`timescale 1ns/1ps
module mbc_phy_model (
   input wire sysClk, busy, hit,
   output reg carrierSense = 0, collision = 0, phyRxValid = 0,
   output reg [7:0] phyRxData = 8'h00
);
   always @(posedge sysClk) begin
      carrierSense <= busy;
      collision <= hit;
      phyRxValid <= !phyRxValid;
      phyRxData <= phyRxValid ? ~phyRxData : ~phyRxData + 8'h01;
   end
endmodule // mbc_phy_model

//--- bench/mbc_mac_ctrl_tb.sv
// Self-checking bench for the MAC control block
`timescale 1ns/1ps
module mbc_mac_ctrl_tb;
   reg sysClk = 0, rst_n = 0, backoffLimitWe = 0, deferralCheckEnIn = 0;
   reg transmitterEnableIn = 0, receiverEnableIn = 0, rxDmaStartStop = 0;
   reg txFrameReady = 0, busy = 0, hit = 0;
   reg [1:0] backoffLimitIn = 2'h0;
   reg [4:0] retryCount = 5'h00;
   wire carrierSense, collision, phyRxValid, txStart, txBackoffBusy_ff;
   wire txDeferAbort_ff, rxValid_ff, rxProcessState_ff, deferralCheckEn_ff;
   wire rxProcessStoppedFlag_ff, transmitterEnable_ff, receiverEnable_ff;
   wire [7:0] phyRxData, rxData_ff;
   wire [1:0] backoffLimitSel_ff;
   integer n_errors = 0, n_compared = 0, n;
   mbc_mac_ctrl #(.BIT_CYCLES(8'd1)) i_dut (.*);
   mbc_phy_model i_phy (.*);
   task check(input [15:0] seen, exp, input [63:0] what);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("unexpected %0s exp %0h seen %0h", what, exp, seen);
      end
      $display("end %0s", what);
   endtask
   task automatic tick(input integer k);
      repeat (k) @(posedge sysClk);
   endtask
   task automatic rxCount;
      n = 0;
      repeat (6) begin
         tick(1);
         n = n + rxValid_ff;
      end
   endtask
   task automatic backoff(input [4:0] r, input [1:0] l, input integer s);
      backoffLimitIn <= l;
      retryCount <= r;
      backoffLimitWe <= 1'h1;
      hit <= 1'h1;
      tick(1);
      backoffLimitWe <= 1'h0;
      hit <= 1'h0;
      tick(2);
      for (n = 0; txBackoffBusy_ff === 1'h1 && n < 9000; n = n + 1) tick(1);
      check(n > 0 && n <= s * 512 + 2, 1, "backoff");
      check(backoffLimitSel_ff, l, "limit");
   endtask
   task final_report;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial forever #10 sysClk = ~sysClk;
   initial begin
      repeat (100000) @(posedge sysClk);
      n_errors = n_errors + 1;
      final_report;
   end
   initial begin
      tick(8);
      rst_n <= 1'h1;
      tick(2);
      check({backoffLimitSel_ff, transmitterEnable_ff, receiverEnable_ff,
         deferralCheckEn_ff}, 0, "reset");
      rxCount;
      check(n, 0, "rxoff");
      rxDmaStartStop <= 1'h1;
      tick(2);
      receiverEnableIn <= 1'h1;
      tick(3);
      rxCount;
      check(n, 3, "rxon");
      rxDmaStartStop <= 1'h0;
      tick(4);
      check({rxProcessState_ff, rxProcessStoppedFlag_ff}, 2, "dmastop");
      receiverEnableIn <= 1'h0;
      tick(4);
      check({rxProcessState_ff, rxProcessStoppedFlag_ff}, 1, "stopped");
      backoff(5'h00, 2'h0, 1);
      backoff(5'h03, 2'h1, 8);
      backoff(5'h0a, 2'h2, 16);
      backoff(5'h0a, 2'h3, 2);
      txFrameReady <= 1'h1;
      transmitterEnableIn <= 1'h1;
      tick(3);
      check(txStart, 1, "txon");
      transmitterEnableIn <= 1'h0;
      tick(3);
      check(txStart, 0, "txoff");
      transmitterEnableIn <= 1'h1;
      deferralCheckEnIn <= 1'h1;
      busy <= 1'h1;
      tick(5000);
      busy <= 1'h0;
      tick(3);
      busy <= 1'h1;
      for (n = 0; txDeferAbort_ff !== 1'h1 && n < 30000; n = n + 1) tick(1);
      check(n > 24288 && n < 24296, 1, "defer");
      deferralCheckEnIn <= 1'h0;
      tick(24400);
      check(txDeferAbort_ff, 0, "nolimit");
      final_report;
   end
endmodule // mbc_mac_ctrl_tb
